/* File: hw/dma_act_consts.vh */
// constants for the dma activate transport sequencer
// assumes one 100 MHz clock and same-clock link, dma and app logic
// Functional notes
// - enter receive state on dma activate frame
// - resolve direction, no error goes outbound wait, or inbound if device to host
// - receive error: status to link, app; idle
// - illegal transition notice in receive, outbound active or inbound sends sequencer idle
// - outbound wait holds until controller initialised
// - outbound soft reset: sync escape, then idle
// - outbound active: enable dma, forward payload
// - 2048 dwords sent: close frame, end
// - abort primitive in outbound active: completion
// - transfer complete moves to completion state
// - completion waits controller done or a full frame, idle if clean
// - completion error: status to link, app; app only on abort
// - abort in completion: truncate, crc, end
// - inbound data trusted only after completion status
// - inbound: enable dma once initialised, write dwords to fifo
// - inbound persists; data held until dma ready
// - inbound soft reset or packet reset: sync
// - activate answered by outbound data frames, or inbound ones if device to host
`ifndef DMA_ACT_CONSTS_VH
`define DMA_ACT_CONSTS_VH

`define FRAME_DWORD_LIMIT 2048
`define FRAME_CNT_W 12
`define DWORD_W 32
`define STATE_W 6
`define ZERO_DWORD 32'h0000_0000

`endif

/* File: hw/dword_frame_counter.v */
// per-frame payload dword counter with limit flag
// assumes clear and count enables come from the same clock domain
`timescale 1ns/10ps
module dword_frame_counter #(
  parameter CNT_W = 12,
  parameter LIMIT = 2048
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire clear_i,
  input wire inc_i,
  output wire hit_o
);
  localparam [CNT_W-1:0] LIM = LIMIT[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  reg [CNT_W-1:0] cnt_ff;

  // clear wins over increment
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= {CNT_W{1'b0}};
    end else if (clear_i) begin
      cnt_ff <= {CNT_W{1'b0}};
    end else if (inc_i) begin
      cnt_ff <= cnt_ff + ONE;
    end
  end

  assign hit_o = (cnt_ff == LIM);
endmodule

/* File: hw/host_dma_activate_transport.v */
// host transport sequencer for a received dma activate frame
// assumes link, dma controller and app logic share ref_clk_i
`timescale 1ns/10ps
`include "dma_act_consts.vh"
module host_dma_activate_transport #(
  parameter DW = `DWORD_W,
  parameter CNT_W = `FRAME_CNT_W,
  parameter FRAME_LIMIT = `FRAME_DWORD_LIMIT
) (
  input wire ref_clk_i,
  input wire resetn_i,
  // link: frame arrival and status
  input wire fis_rx_start_i,
  input wire fis_is_dma_act_i,
  input wire rx_status_valid_i,
  input wire rx_err_i,
  input wire dir_dev_to_host_i,
  input wire illegal_trans_i,
  input wire dma_abort_i,
  // link: outbound payload
  output wire [DW-1:0] tx_data_o,
  output wire tx_valid_o,
  input wire tx_ready_i,
  output wire tx_close_o,
  output wire tx_crc_end_o,
  output wire sync_escape_o,
  output wire link_status_o,
  // link: inbound payload
  input wire [DW-1:0] rx_data_i,
  input wire rx_valid_i,
  output wire rx_ready_o,
  // data fifo
  output wire [DW-1:0] fifo_wr_data_o,
  output wire fifo_wr_en_o,
  input wire fifo_full_i,
  // dma controller
  input wire dma_init_i,
  output wire dma_enable_o,
  input wire [DW-1:0] dma_rd_data_i,
  input wire dma_rd_valid_i,
  output wire dma_rd_ready_o,
  input wire dma_xfer_done_i,
  input wire dma_idle_i,
  input wire dma_err_i,
  // application
  input wire srst_i,
  input wire dev_reset_cmd_i,
  input wire packet_dev_i,
  input wire cmd_status_i,
  output wire app_status_o,
  output wire rx_data_trusted_o,
  output wire [`STATE_W-1:0] state_o
);
  // one-hot sequencer states
  localparam [`STATE_W-1:0] ST_IDLE = 6'h01;
  localparam [`STATE_W-1:0] ST_RECV = 6'h02;
  localparam [`STATE_W-1:0] ST_OWAIT = 6'h04;
  localparam [`STATE_W-1:0] ST_OACT = 6'h08;
  localparam [`STATE_W-1:0] ST_END = 6'h10;
  localparam [`STATE_W-1:0] ST_ITRANS = 6'h20;

  // reset release through two flops
  reg rst_meta_ff;
  reg rst_n_ff;
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // sequencer state and one-cycle pulse registers
  reg [`STATE_W-1:0] state_ff;
  reg [`STATE_W-1:0] nxt_state;
  // outbound payload stage
  reg [DW-1:0] tx_data_ff;
  reg tx_valid_ff;
  reg tx_close_ff;
  reg nxt_tx_close;
  reg tx_crc_end_ff;
  reg nxt_tx_crc_end;
  reg sync_ff;
  reg nxt_sync;
  reg link_status_ff;
  reg nxt_link_status;
  reg app_status_ff;
  reg nxt_app_status;
  // fifo stage and trust tracking
  reg [DW-1:0] fifo_data_ff;
  reg fifo_wr_ff;
  reg inbound_seen_ff;
  reg trusted_ff;
  reg limit_ff;
  reg nxt_limit;

  // state decodes and handshakes
  wire frame_hit;
  wire in_idle = (state_ff == ST_IDLE);
  wire in_oact = (state_ff == ST_OACT);
  wire in_itrans = (state_ff == ST_ITRANS);
  wire soft_rst = srst_i | dev_reset_cmd_i;
  wire in_soft_rst = srst_i | (dev_reset_cmd_i & packet_dev_i);
  wire tx_take = tx_valid_ff & tx_ready_i;
  // staged dword is gone or leaves this cycle
  wire stage_free = ~tx_valid_ff | tx_ready_i;
  // any reason to stop pulling payload from the dma controller
  wire load_stop = frame_hit | dma_xfer_done_i | illegal_trans_i | soft_rst | dma_abort_i;
  wire load_ok = in_oact & ~load_stop;
  wire dma_take = dma_rd_valid_i & dma_rd_ready_o;
  wire enter_oact = (state_ff == ST_OWAIT) & (nxt_state == ST_OACT);
  // frame full and its last dword handed to the link
  wire frame_end = frame_hit & stage_free;

  // dwords pulled for the current frame
  // counting loads, not link takes, keeps the staged dword inside the limit
  dword_frame_counter #(
    .CNT_W(CNT_W),
    .LIMIT(FRAME_LIMIT)
  ) u_frame_cnt (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .clear_i(enter_oact),
    .inc_i(dma_take),
    .hit_o(frame_hit)
  );

  // next state and one-cycle link/app pulses
  always @* begin
    // pulses default low, state holds
    nxt_state = state_ff;
    nxt_tx_close = 1'b0;
    nxt_tx_crc_end = 1'b0;
    nxt_sync = 1'b0;
    nxt_link_status = 1'b0;
    nxt_app_status = 1'b0;
    nxt_limit = limit_ff;
    case (state_ff)
      // wait for an activate frame
      ST_IDLE: begin
        if (fis_rx_start_i & fis_is_dma_act_i) begin
          nxt_state = ST_RECV;
        end
      end
      // resolve direction once status is posted
      ST_RECV: begin
        if (illegal_trans_i) begin
          nxt_state = ST_IDLE;
        end else if (rx_status_valid_i & rx_err_i) begin
          nxt_link_status = 1'b1;
          nxt_app_status = 1'b1;
          nxt_state = ST_IDLE;
        end else if (rx_status_valid_i & dir_dev_to_host_i) begin
          nxt_state = ST_ITRANS;
        end else if (rx_status_valid_i) begin
          nxt_state = ST_OWAIT;
        end
      end
      // outbound: wait for controller setup
      ST_OWAIT: begin
        if (soft_rst) begin
          nxt_sync = 1'b1;
          nxt_state = ST_IDLE;
        end else if (dma_init_i) begin
          nxt_state = ST_OACT;
          nxt_limit = 1'b0;
        end
      end
      // outbound: stream payload to the link
      ST_OACT: begin
        if (illegal_trans_i) begin
          nxt_state = ST_IDLE;
        end else if (soft_rst) begin
          nxt_sync = 1'b1;
          nxt_state = ST_IDLE;
        end else if (dma_abort_i) begin
          nxt_state = ST_END;
        end else if (dma_xfer_done_i & ~tx_valid_ff) begin
          nxt_tx_close = 1'b1;
          nxt_state = ST_END;
        end else if (frame_end) begin
          nxt_tx_close = 1'b1;
          nxt_limit = 1'b1;
          nxt_state = ST_END;
        end
      end
      // wait for the controller to finish
      ST_END: begin
        if (dma_abort_i) begin
          nxt_tx_crc_end = 1'b1;
          nxt_app_status = dma_err_i;
          nxt_state = ST_IDLE;
          // a full frame counts as finished without the idle flag
        end else if (dma_idle_i | limit_ff) begin
          nxt_link_status = dma_err_i;
          nxt_app_status = dma_err_i;
          nxt_state = ST_IDLE;
        end
      end
      // inbound: dwords into the data fifo
      ST_ITRANS: begin
        if (illegal_trans_i) begin
          nxt_state = ST_IDLE;
        end else if (in_soft_rst) begin
          nxt_sync = 1'b1;
          nxt_state = ST_IDLE;
        end else if (dma_xfer_done_i) begin
          nxt_state = ST_END;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state and pulse registers
  always @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ST_IDLE;
      tx_close_ff <= 1'b0;
      tx_crc_end_ff <= 1'b0;
      sync_ff <= 1'b0;
      link_status_ff <= 1'b0;
      app_status_ff <= 1'b0;
      limit_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tx_close_ff <= nxt_tx_close;
      tx_crc_end_ff <= nxt_tx_crc_end;
      sync_ff <= nxt_sync;
      link_status_ff <= nxt_link_status;
      app_status_ff <= nxt_app_status;
      limit_ff <= nxt_limit;
    end
  end

  // outbound payload stage between dma controller and link
  always @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tx_data_ff <= `ZERO_DWORD;
      tx_valid_ff <= 1'b0;
    end else if (!in_oact || nxt_state != ST_OACT) begin
      tx_valid_ff <= 1'b0;
    end else if (dma_take) begin
      tx_data_ff <= dma_rd_data_i;
      tx_valid_ff <= 1'b1;
    end else if (tx_take) begin
      tx_valid_ff <= 1'b0;
    end
  end

  // inbound dwords into the data fifo
  always @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      fifo_data_ff <= `ZERO_DWORD;
      fifo_wr_ff <= 1'b0;
    end else begin
      fifo_wr_ff <= rx_valid_i & rx_ready_o;
      if (rx_valid_i & rx_ready_o) begin
        fifo_data_ff <= rx_data_i;
      end
    end
  end

  // inbound data stays provisional until completion status returns
  always @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      inbound_seen_ff <= 1'b0;
      trusted_ff <= 1'b0;
    end else if (in_itrans) begin
      inbound_seen_ff <= 1'b1;
      trusted_ff <= 1'b0;
    end else if (inbound_seen_ff & cmd_status_i & in_idle) begin
      inbound_seen_ff <= 1'b0;
      trusted_ff <= 1'b1;
    end else if (fis_rx_start_i) begin
      trusted_ff <= 1'b0;
    end
  end

  // dma enabled only in active transfer states
  assign dma_enable_o = in_oact | (in_itrans & dma_init_i);
  assign dma_rd_ready_o = load_ok & stage_free;
  // hold inbound data while the fifo is full or dma not programmed
  // and pause one cycle after each dword taken
  assign rx_ready_o = in_itrans & dma_init_i & ~fifo_full_i & ~fifo_wr_ff;

  // outbound link outputs straight from their registers
  assign tx_data_o = tx_data_ff;
  assign tx_valid_o = tx_valid_ff;
  assign tx_close_o = tx_close_ff;
  assign tx_crc_end_o = tx_crc_end_ff;
  assign sync_escape_o = sync_ff;
  assign link_status_o = link_status_ff;

  // fifo write port
  assign fifo_wr_data_o = fifo_data_ff;
  assign fifo_wr_en_o = fifo_wr_ff;

  // application side
  assign app_status_o = app_status_ff;
  assign rx_data_trusted_o = trusted_ff;
  assign state_o = state_ff;
endmodule

/* File: bench/host_dma_activate_transport_asserts.sv */
// checker for the dma activate transport sequencer
// assumes binding to the top module, seeing only its ports
`timescale 1ns/10ps
module host_dma_activate_transport_asserts (
  input wire ref_clk_i,
  input wire resetn_i,
  input wire fis_rx_start_i,
  input wire fis_is_dma_act_i,
  input wire rx_status_valid_i,
  input wire rx_err_i,
  input wire dir_dev_to_host_i,
  input wire illegal_trans_i,
  input wire dma_abort_i,
  input wire srst_i,
  input wire dev_reset_cmd_i,
  input wire dma_init_i,
  input wire rx_valid_i,
  input wire rx_ready_o,
  input wire fifo_wr_en_o,
  input wire dma_enable_o,
  input wire sync_escape_o,
  input wire link_status_o,
  input wire app_status_o,
  input wire [5:0] state_o
);
  // one domain for every property
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_recv_entry: assert property (
    state_o == 6'h01 && fis_rx_start_i && fis_is_dma_act_i |=> state_o == 6'h02)
    else $error("receive state not entered");
  chk_recv_ok: assert property (
    state_o == 6'h02 && !illegal_trans_i && rx_status_valid_i && !rx_err_i
    && !dir_dev_to_host_i |=> state_o == 6'h04) else $error("no outbound wait");
  chk_recv_err: assert property (
    state_o == 6'h02 && !illegal_trans_i && rx_status_valid_i && rx_err_i
    |=> state_o == 6'h01 && link_status_o && app_status_o) else $error("bad error exit");
  chk_illegal_idle: assert property (
    (state_o & 6'h2a) != 6'h00 && illegal_trans_i |=> state_o == 6'h01)
    else $error("illegal notice ignored");
  chk_wait_hold: assert property (
    state_o == 6'h04 && !dma_init_i && !srst_i && !dev_reset_cmd_i |=> state_o == 6'h04)
    else $error("left wait early");
  chk_out_sync: assert property (
    (state_o & 6'h0c) != 6'h00 && !illegal_trans_i && (srst_i || dev_reset_cmd_i)
    |=> sync_escape_o && state_o == 6'h01) else $error("no sync on reset");
  chk_out_enable: assert property (
    state_o == 6'h08 |-> dma_enable_o) else $error("dma not enabled");
  chk_abort_end: assert property (
    state_o == 6'h08 && dma_abort_i && !illegal_trans_i && !srst_i && !dev_reset_cmd_i
    |=> state_o == 6'h10) else $error("abort not ending");
  chk_in_hold: assert property (
    state_o == 6'h20 && !dma_init_i |-> !rx_ready_o) else $error("took data early");
  chk_fifo_write: assert property (
    fifo_wr_en_o |-> $past(rx_valid_i & rx_ready_o)) else $error("write without dword");
endmodule

/* File: bench/link_partner_model.sv */
// link layer stand-in: takes outbound dwords, feeds inbound ones
// assumes handshakes are sampled on the rising edge
`timescale 1ns/10ps
module link_partner_model (
  input wire ref_clk_i,
  input wire slow_i,
  input wire rx_en_i,
  output reg tx_ready_o = 1'b0,
  input wire rx_ready_i,
  output reg rx_valid_o = 1'b0,
  output wire [31:0] rx_data_o
);
  reg [31:0] cnt_ff = 32'h0;
  reg tick_ff = 1'b0;
  // accept each cycle, or every other one when slow
  always @(posedge ref_clk_i) begin
    tick_ff <= ~tick_ff;
    tx_ready_o <= ~slow_i | tick_ff;
  end
  // inbound words held until taken, counting up
  always @(posedge ref_clk_i) begin
    rx_valid_o <= rx_en_i | (rx_valid_o & ~rx_ready_i);
    if (rx_valid_o & rx_ready_i) begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
  // idle data is inverted so it never looks stale
  assign rx_data_o = rx_valid_o ? cnt_ff : ~cnt_ff;
endmodule

/* File: bench/host_dma_activate_transport_test.sv */
// testbench for the dma activate transport sequencer
// assumes the link stand-in and the checker are compiled before it
`timescale 1ns/10ps
module host_dma_activate_transport_test;
  reg clk = 0, rstn = 0, start = 0, act = 0, stv = 0, err = 0, dir = 0, ill = 0;
  reg abt = 0, init = 0, done = 0, idle = 0, srst = 0, drst = 0, pkt = 0, slow = 0, rxen = 0;
  reg derr = 0, cst = 0, full = 0;
  reg [31:0] rd_data = 32'h0;
  reg [31:0] ld_q = 32'h0;
  wire den, trust;
  reg [4:0] pul = 5'h0;
  wire [31:0] tx_data, rx_data, f_data;
  wire tx_valid, tx_ready, close, crcend, sync, lst, ast, rx_valid, rx_ready, wr_en, rd_rdy;
  wire [5:0] st;
  integer n_mismatch = 0, compares = 0, cyc = 0, ntx = 0, nwr = 0, i, k;
  always #5 clk = ~clk;
  host_dma_activate_transport #(.FRAME_LIMIT(8)) dut_u (.ref_clk_i(clk), .resetn_i(rstn),
    .fis_rx_start_i(start), .fis_is_dma_act_i(act), .rx_status_valid_i(stv), .rx_err_i(err),
    .dir_dev_to_host_i(dir), .illegal_trans_i(ill), .dma_abort_i(abt), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_close_o(close), .tx_crc_end_o(crcend),
    .sync_escape_o(sync), .link_status_o(lst), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
    .rx_ready_o(rx_ready), .fifo_wr_data_o(f_data), .fifo_wr_en_o(wr_en), .fifo_full_i(full),
    .dma_init_i(init), .dma_enable_o(den), .dma_rd_data_i(rd_data), .dma_rd_valid_i(1'b1),
    .dma_rd_ready_o(rd_rdy), .dma_xfer_done_i(done), .dma_idle_i(idle), .dma_err_i(derr),
    .srst_i(srst), .dev_reset_cmd_i(drst), .packet_dev_i(pkt), .cmd_status_i(cst),
    .app_status_o(ast), .rx_data_trusted_o(trust), .state_o(st));
  link_partner_model link_u (.ref_clk_i(clk), .slow_i(slow), .rx_en_i(rxen),
    .tx_ready_o(tx_ready), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
  task chk(input [8*5:1] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (e !== g) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task finish_test;
    begin
      if (n_mismatch == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // counters, pulse catcher, dma source and fifo data check
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pul <= pul | {close, crcend, sync, lst, ast};
    if (rd_rdy) begin
      rd_data <= rd_data + 32'h1;
      ld_q <= rd_data;
    end
    if (tx_valid & tx_ready) begin
      ntx <= ntx + 1;
      chk("txd", ld_q, tx_data);
    end
    if (wr_en === 1'b1) begin
      chk("fifo", nwr, f_data);
      nwr <= nwr + 1;
    end
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end
  task cy(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wst(input [5:0] s);
    begin
      for (k = 0; k < 200 && st !== s; k = k + 1) @(negedge clk);
      chk("state", s, st);
    end
  endtask
  // frame arrival then reception status
  task go(input d, input e);
    begin
      pul = 5'h0;
      start = 1;
      act = 1;
      cy(1);
      start = 0;
      act = 0;
      cy(1);
      chk("recv", 6'h02, st);
      stv = 1;
      dir = d;
      err = e;
      cy(1);
      stv = 0;
      err = 0;
    end
  endtask
  task t_limit;
    begin
      slow = 1;
      go(0, 0);
      chk("owait", 6'h04, st);
      cy(3);
      chk("hold", 6'h04, st);
      i = ntx;
      init = 1;
      cy(1);
      chk("oact", 6'h08, st);
      wst(6'h10);
      chk("ntx", 8, ntx - i);
      chk("close", 1, close);
      chk("doff", 0, den);
      wst(6'h01);
      slow = 0;
    end
  endtask
  task t_abort;
    begin
      go(0, 0);
      wst(6'h08);
      derr = 1;
      abt = 1;
      cy(1);
      chk("abort", 6'h10, st);
      cy(1);
      abt = 0;
      cy(2);
      chk("crc", 1, pul[3]);
      chk("idle", 6'h01, st);
      chk("astat", 1, pul[1:0]);
      derr = 0;
    end
  endtask
  task t_faults;
    begin
      go(0, 1);
      cy(1);
      chk("err", 6'h01, st);
      chk("stat", 3, pul[1:0]);
      go(1, 0);
      ill = 1;
      cy(1);
      ill = 0;
      chk("ill", 6'h01, st);
      init = 0;
      go(0, 0);
      srst = 1;
      cy(1);
      srst = 0;
      cy(1);
      chk("srst", 6'h01, st);
      chk("sync", 1, pul[2]);
    end
  endtask
  task t_inbound;
    begin
      init = 0;
      rxen = 1;
      go(1, 0);
      chk("in", 6'h20, st);
      chk("den0", 0, den);
      cy(4);
      chk("held", 0, nwr);
      init = 1;
      cy(12);
      chk("wr", 1, nwr > 3);
      chk("den1", 1, den);
      full = 1;
      cy(2);
      i = nwr;
      cy(4);
      chk("full", i, nwr);
      full = 0;
      drst = 1;
      cy(2);
      chk("nopkt", 6'h20, st);
      pkt = 1;
      cy(2);
      chk("pkt", 6'h01, st);
      drst = 0;
      go(1, 0);
      done = 1;
      cy(1);
      done = 0;
      rxen = 0;
      chk("done", 6'h10, st);
      wst(6'h01);
    end
  endtask
  // outbound done with a controller error
  task t_odone;
    begin
      init = 1;
      derr = 1;
      go(0, 0);
      wst(6'h08);
      done = 1;
      wst(6'h10);
      done = 0;
      chk("ocls", 1, close);
      cy(2);
      chk("estat", 3, pul[1:0]);
      chk("eidle", 6'h01, st);
      derr = 0;
    end
  endtask
  // inbound data trusted only after completion status
  task t_trust;
    begin
      chk("untr", 0, trust);
      cst = 1;
      cy(1);
      cst = 0;
      chk("trust", 1, trust);
      go(0, 1);
      chk("retr", 0, trust);
    end
  endtask
  initial begin
    cy(20);
    rstn = 1;
    cy(3);
    idle = 1;
    t_limit;
    idle = 0;
    t_abort;
    t_faults;
    idle = 1;
    t_odone;
    t_inbound;
    t_trust;
    finish_test;
  end
endmodule

bind host_dma_activate_transport host_dma_activate_transport_asserts chk_u (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .fis_rx_start_i(fis_rx_start_i),
  .fis_is_dma_act_i(fis_is_dma_act_i), .rx_status_valid_i(rx_status_valid_i),
  .rx_err_i(rx_err_i), .dir_dev_to_host_i(dir_dev_to_host_i),
  .illegal_trans_i(illegal_trans_i), .dma_abort_i(dma_abort_i), .srst_i(srst_i),
  .dev_reset_cmd_i(dev_reset_cmd_i), .dma_init_i(dma_init_i), .rx_valid_i(rx_valid_i),
  .rx_ready_o(rx_ready_o), .fifo_wr_en_o(fifo_wr_en_o), .dma_enable_o(dma_enable_o),
  .sync_escape_o(sync_escape_o), .link_status_o(link_status_o),
  .app_status_o(app_status_o), .state_o(state_o));
